//--- core/bmsr_consts.vh
`ifndef BMSR_CONSTS_VH
`define BMSR_CONSTS_VH
// Command codes of the readable result words.
`define BMSR_CMD_PROT_A 8'h03
`define BMSR_CMD_PROT_B 8'h05
`define BMSR_CMD_PROT_C 8'h07
`define BMSR_CMD_LAST_A 8'h0b
`define BMSR_CMD_LAST_B 8'h0d
`define BMSR_CMD_LAST_C 8'h0f
`define BMSR_CMD_CURRENT 8'h3a
`define BMSR_CMD_SENSE_1 8'h70
`define BMSR_CMD_SENSE_2 8'h72
`define BMSR_CMD_SENSE_3 8'h74
// Bit position of the cell undervoltage flag in the first fault word.
`define BMSR_PROT_A_UNDERVOLT_BIT 2
// Reset and fallback values.
`define BMSR_RESET_WORD 16'h0000
`define BMSR_UNMAPPED_WORD 16'h0000
// Seven-bit target address on the serial bus; value is arbitrary.
`define BMSR_TARGET_ADDR 7'h08
`endif

//--- core/bmsr_sync.v
// Two-stage synchroniser for an input arriving from outside the clock domain.
module bmsr_sync (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_async,
    output reg o_sync
);
    reg stage_one_reg;

    // The first stage is read only by the second stage.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage_one_reg <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            stage_one_reg <= i_async;
            o_sync <= stage_one_reg;
        end
    end
endmodule // bmsr_sync

//--- core/bmsr_readout.v
// Functional notes
// - Three fault status words at 0x03/0x05/0x07.
// - Undervoltage sets bit two of first word.
// - Three lasting failure words at 0x0b/0x0d/0x0f.
// - No lasting failure means zero words.
// - Current result at 0x3a, one count milliamp.
// - Current result is sixteen bits wide.
// - Thermistor pin results in tenth kelvin.
// - Analog input mode returns pin millivolts.
// - Unconfigured pin yields no meaningful result.
// - Results go out low byte first.
`include "bmsr_consts.vh"
module bmsr_readout (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_oe_n,
    input wire [7:0] i_protection_fault_flags_a,
    input wire [7:0] i_protection_fault_flags_b,
    input wire [7:0] i_protection_fault_flags_c,
    input wire i_cell_undervoltage,
    input wire [7:0] i_lasting_failure_flags_a,
    input wire [7:0] i_lasting_failure_flags_b,
    input wire [7:0] i_lasting_failure_flags_c,
    input wire [15:0] i_secondary_current_converter,
    input wire [2:0] i_pin_configured,
    input wire [2:0] i_general_analog_input_mode,
    input wire [15:0] i_thermistor_pin_one_kelvin,
    input wire [15:0] i_thermistor_pin_two_kelvin,
    input wire [15:0] i_thermistor_pin_three_kelvin,
    input wire [15:0] i_thermistor_pin_one_mv,
    input wire [15:0] i_thermistor_pin_two_mv,
    input wire [15:0] i_thermistor_pin_three_mv,
    output reg [7:0] o_command_reg
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_ADDR = 5'b00010;
    localparam ST_ACK = 5'b00100;
    localparam ST_WRITE = 5'b01000;
    localparam ST_READ = 5'b10000;

    wire scl_sync;
    wire sda_sync;
    reg scl_prev_reg;
    reg sda_prev_reg;
    reg [4:0] state_reg;
    reg [3:0] bit_count_reg;
    reg [7:0] shift_reg;
    reg reading_reg;
    reg [15:0] snapshot_reg;
    reg byte_sel_reg;
    reg host_ack_reg;

    bmsr_sync u_sync_scl (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_scl),
        .o_sync(scl_sync)
    );
    bmsr_sync u_sync_sda (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_sda),
        .o_sync(sda_sync)
    );

    // Maps a thermistor pin to its result word by mode and configuration.
    function [15:0] sense_word;
        input configured;
        input analog_mode;
        input [15:0] kelvin;
        input [15:0] millivolt;
        begin
            if (!configured) begin
                sense_word = `BMSR_RESET_WORD;
            end else if (analog_mode) begin
                sense_word = millivolt;
            end else begin
                sense_word = kelvin;
            end
        end
    endfunction

    // Result word selected by the command code in force.
    reg [15:0] result_word;
    always @* begin
        case (o_command_reg)
            `BMSR_CMD_PROT_A: begin
                result_word = {8'h00, i_protection_fault_flags_a};
                result_word[`BMSR_PROT_A_UNDERVOLT_BIT] = i_cell_undervoltage;
            end
            `BMSR_CMD_PROT_B: result_word = {8'h00, i_protection_fault_flags_b};
            `BMSR_CMD_PROT_C: result_word = {8'h00, i_protection_fault_flags_c};
            // Lasting failure words are all zero while no failure is flagged.
            `BMSR_CMD_LAST_A: result_word = {8'h00, i_lasting_failure_flags_a};
            `BMSR_CMD_LAST_B: result_word = {8'h00, i_lasting_failure_flags_b};
            `BMSR_CMD_LAST_C: result_word = {8'h00, i_lasting_failure_flags_c};
            `BMSR_CMD_CURRENT: result_word = i_secondary_current_converter;
            `BMSR_CMD_SENSE_1: result_word = sense_word(i_pin_configured[0],
                i_general_analog_input_mode[0], i_thermistor_pin_one_kelvin,
                i_thermistor_pin_one_mv);
            `BMSR_CMD_SENSE_2: result_word = sense_word(i_pin_configured[1],
                i_general_analog_input_mode[1], i_thermistor_pin_two_kelvin,
                i_thermistor_pin_two_mv);
            `BMSR_CMD_SENSE_3: result_word = sense_word(i_pin_configured[2],
                i_general_analog_input_mode[2], i_thermistor_pin_three_kelvin,
                i_thermistor_pin_three_mv);
            default: result_word = `BMSR_UNMAPPED_WORD;
        endcase
    end

    // Edge and bus-condition detectors, all on the synchronised pin levels.
    wire scl_rise = scl_sync && !scl_prev_reg;
    wire scl_fall = !scl_sync && scl_prev_reg;
    wire start_seen = scl_sync && scl_prev_reg && sda_prev_reg && !sda_sync;
    wire stop_seen = scl_sync && scl_prev_reg && !sda_prev_reg && sda_sync;

    // Serial target engine: address, command byte, then streamed result bytes.
    // Sampling at 25 MHz keeps up with the host model's 1.5625 MHz bus clock, 16 samples a bit.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_count_reg <= 4'h0;
            shift_reg <= 8'h00;
            reading_reg <= 1'b0;
            snapshot_reg <= `BMSR_RESET_WORD;
            byte_sel_reg <= 1'b0;
            host_ack_reg <= 1'b0;
            o_command_reg <= 8'h00;
            o_sda_oe_n <= 1'b1;
        end else begin
            scl_prev_reg <= scl_sync;
            sda_prev_reg <= sda_sync;
            if (start_seen) begin
                state_reg <= ST_ADDR;
                bit_count_reg <= 4'h0;
                o_sda_oe_n <= 1'b1;
            end else if (stop_seen) begin
                state_reg <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
            end else begin
                case (state_reg)
                    ST_IDLE: o_sda_oe_n <= 1'b1;
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_sync};
                            bit_count_reg <= bit_count_reg + 4'h1;
                        end else if (scl_fall && bit_count_reg == 4'h8) begin
                            bit_count_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (shift_reg[7:1] == `BMSR_TARGET_ADDR) begin
                                    reading_reg <= shift_reg[0];
                                    o_sda_oe_n <= 1'b0;
                                    state_reg <= ST_ACK;
                                    // Freeze the word so both bytes match.
                                    snapshot_reg <= result_word;
                                    byte_sel_reg <= 1'b0;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                o_command_reg <= shift_reg;
                                o_sda_oe_n <= 1'b0;
                                state_reg <= ST_ACK;
                            end
                        end
                    end
                    // The acknowledge bit stands until the host lowers the clock again.
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (reading_reg) begin
                                state_reg <= ST_READ;
                                shift_reg <= byte_sel_reg ? snapshot_reg[15:8] :
                                    snapshot_reg[7:0];
                                o_sda_oe_n <= byte_sel_reg ? snapshot_reg[15] :
                                    snapshot_reg[7];
                                bit_count_reg <= 4'h1;
                            end else begin
                                state_reg <= ST_WRITE;
                                o_sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    // Each data bit is set up after a falling clock and held to the next.
                    // The host's acknowledge is taken on the ninth rising clock of a byte,
                    // so a missing acknowledge ends the read without driving the bus.
                    ST_READ: begin
                        if (scl_rise && bit_count_reg == 4'h9) begin
                            host_ack_reg <= !sda_sync;
                        end else if (scl_fall) begin
                            if (bit_count_reg == 4'h8) begin
                                o_sda_oe_n <= 1'b1;
                                bit_count_reg <= 4'h9;
                            end else if (bit_count_reg == 4'h9) begin
                                if (host_ack_reg) begin
                                    // High byte follows the low byte.
                                    byte_sel_reg <= !byte_sel_reg;
                                    shift_reg <= byte_sel_reg ? snapshot_reg[7:0] :
                                        snapshot_reg[15:8];
                                    o_sda_oe_n <= byte_sel_reg ? snapshot_reg[7] :
                                        snapshot_reg[15];
                                    bit_count_reg <= 4'h1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                o_sda_oe_n <= shift_reg[6];
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                bit_count_reg <= bit_count_reg + 4'h1;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // bmsr_readout

//--- verification/bmsr_readout_properties.sv
module bmsr_readout_properties (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_oe_n,
    input wire logic [7:0] o_command_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    logic [3:0] low_bits;
    // SCL pulses seen during one unbroken stretch of the device pulling SDA low.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_bits <= 4'h0;
        end else begin
            low_bits <= o_sda_oe_n ? 4'h0 : low_bits + {3'h0, $rose(i_scl)};
        end
    end
    // SDA may only move once the synchronised SCL low has been seen.
    sequence s_scl_was_low;
        !$past(i_scl, 2) && !$past(i_scl, 3);
    endsequence
    a_drive_after_fall: assert property ($fell(o_sda_oe_n) |-> s_scl_was_low)
        else $error("sda pulled outside scl low");
    a_release_after_fall: assert property ($rose(o_sda_oe_n) |-> s_scl_was_low)
        else $error("sda released outside scl low");
    a_steady_scl_high: assert property ($rose(i_scl) |=> $stable(o_sda_oe_n) [*4])
        else $error("sda moved while scl high");
    a_start_by_host: assert property (i_scl && $fell(i_sda) |-> o_sda_oe_n)
        else $error("device made a start");
    a_stop_released: assert property (i_scl && $rose(i_sda) |=> o_sda_oe_n [*4])
        else $error("device drove sda after stop");
    a_cmd_steady: assert property (i_scl && !o_sda_oe_n |-> $stable(o_command_reg))
        else $error("command changed during transfer");
    // A zero byte after an acknowledge is the longest legal pull.
    a_drive_span: assert property (low_bits <= 4'h9)
        else $error("sda held low too many bits");
    a_reset_idle: assert property ($rose(i_reset_n) |-> o_sda_oe_n && o_command_reg == 8'h00)
        else $error("not idle after reset");
endmodule // bmsr_readout_properties
bind bmsr_readout bmsr_readout_properties bmsr_readout_properties_i (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe_n(o_sda_oe_n),
    .o_command_reg(o_command_reg));

//--- verification/bmsr_host_model.sv
module bmsr_host_model (
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idles released; the pull-up makes SDA high.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // SDA moves mid-low so it never races SCL through the synchronisers.
    task automatic put_bit(input logic b);
        hold(4);
        o_sda_low = !b;
        hold(4);
        o_scl = 1'b1;
        hold(8);
        o_scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        put_bit(1'b1);
        b = i_sda;
    endtask
    // Release SDA while SCL is low, raise SCL, then pull SDA: no extra clock pulse.
    task automatic start();
        hold(4);
        o_sda_low = 1'b0;
        hold(4);
        o_scl = 1'b1;
        hold(8);
        o_sda_low = 1'b1;
        hold(8);
        o_scl = 1'b0;
    endtask
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(b);
        ack = !b;
    endtask
    // Bits are sampled at the end of the high phase, while they still stand.
    task automatic byte_in(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(last);
    endtask
    // Command byte, repeated start, then two bytes low first and a stop.
    task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w,
            output logic ok);
        logic k0, k1, k2;
        w = 16'h0000;
        k1 = 1'b0;
        k2 = 1'b0;
        start();
        byte_out({a, 1'b0}, k0);
        if (k0) begin
            byte_out(c, k1);
            start();
            byte_out({a, 1'b1}, k2);
            byte_in(1'b0, w[7:0]);
            byte_in(1'b1, w[15:8]);
        end
        hold(4);
        o_sda_low = 1'b1;
        hold(4);
        o_scl = 1'b1;
        hold(8);
        o_sda_low = 1'b0;
        hold(8);
        ok = k0 && k1 && k2;
    endtask
endmodule // bmsr_host_model

//--- verification/test_battery_monitor_status_readout.sv
`include "bmsr_consts.vh"
module test_battery_monitor_status_readout;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset_n, scl, sda_low, oe_n, uv;
    logic [7:0] pa, pb, pc, la, lb, lc, cmd;
    logic [15:0] cur, k1, k2, k3, m1, m2, m3;
    logic [2:0] cfg, ana;
    int mismatches = 0;
    int compares = 0;
    // Open-drain wire with a pull-up.
    wire sda = !sda_low && oe_n;
    bmsr_host_model bmsr_host_model_i (.i_clock(clock), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));
    bmsr_readout bmsr_readout_i (.i_clock(clock), .i_reset_n(reset_n), .i_scl(scl),
        .i_sda(sda), .o_sda_oe_n(oe_n), .i_protection_fault_flags_a(pa),
        .i_protection_fault_flags_b(pb), .i_protection_fault_flags_c(pc),
        .i_cell_undervoltage(uv), .i_lasting_failure_flags_a(la),
        .i_lasting_failure_flags_b(lb), .i_lasting_failure_flags_c(lc),
        .i_secondary_current_converter(cur), .i_pin_configured(cfg),
        .i_general_analog_input_mode(ana), .i_thermistor_pin_one_kelvin(k1),
        .i_thermistor_pin_two_kelvin(k2), .i_thermistor_pin_three_kelvin(k3),
        .i_thermistor_pin_one_mv(m1), .i_thermistor_pin_two_mv(m2),
        .i_thermistor_pin_three_mv(m3), .o_command_reg(cmd));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic finish_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // One full read; the command register must keep the code just written.
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] w;
        logic ok;
        bmsr_host_model_i.read_word(`BMSR_TARGET_ADDR, c, w, ok);
        chk("acknowledge", 16'h0001, {15'h0, ok});
        chk("word", e, w);
        chk("command", {8'h00, c}, {8'h00, cmd});
    endtask
    task automatic t_protection();
        @(negedge clock);
        {pa, pb, pc, uv} = {8'h00, 8'h5a, 8'ha5, 1'b1};
        rd(`BMSR_CMD_PROT_A, 16'h0004);
        rd(`BMSR_CMD_PROT_B, 16'h005a);
        rd(`BMSR_CMD_PROT_C, 16'h00a5);
        {pa, uv} = {8'hfb, 1'b0};
        rd(`BMSR_CMD_PROT_A, 16'h00fb);
        {pa, uv} = {8'h04, 1'b0};
        rd(`BMSR_CMD_PROT_A, 16'h0000);
    endtask
    task automatic t_lasting_current();
        rd(`BMSR_CMD_LAST_A, 16'h0000);
        rd(`BMSR_CMD_LAST_C, 16'h0000);
        {la, lb, lc, cur} = {8'h81, 8'h42, 8'h24, 16'hbe0f};
        rd(`BMSR_CMD_LAST_A, 16'h0081);
        rd(`BMSR_CMD_LAST_B, 16'h0042);
        rd(`BMSR_CMD_LAST_C, 16'h0024);
        rd(`BMSR_CMD_CURRENT, 16'hbe0f);
        rd(8'h3b, 16'h0000);
    endtask
    task automatic t_sense();
        {cfg, ana} = {3'b101, 3'b100};
        rd(`BMSR_CMD_SENSE_1, 16'h0b9d);
        rd(`BMSR_CMD_SENSE_2, 16'h0000);
        rd(`BMSR_CMD_SENSE_3, 16'h0c35);
        {cfg, ana} = {3'b111, 3'b010};
        rd(`BMSR_CMD_SENSE_2, 16'h0777);
        rd(`BMSR_CMD_SENSE_3, 16'h0b9a);
        {cfg, ana} = {3'b111, 3'b001};
        rd(`BMSR_CMD_SENSE_1, 16'h0aaa);
        rd(`BMSR_CMD_SENSE_2, 16'h0bb8);
    endtask
    // Reset in mid-run must clear the command and release the bus, then reads resume.
    task automatic t_reset();
        @(negedge clock);
        reset_n = 1'b0;
        repeat (3) @(negedge clock);
        chk("command in reset", 16'h0000, {8'h00, cmd});
        chk("release in reset", 16'h0001, {15'h0, oe_n});
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        chk("command after reset", 16'h0000, {8'h00, cmd});
        rd(`BMSR_CMD_PROT_B, 16'h005a);
    endtask
    // The input moves while the low byte is on the wire.
    task automatic t_freeze_refuse();
        logic [15:0] w;
        logic ok;
        fork
            rd(`BMSR_CMD_CURRENT, 16'hbe0f);
            begin
                repeat (550) @(negedge clock);
                cur = 16'h5678;
            end
        join
        bmsr_host_model_i.read_word(7'h09, `BMSR_CMD_PROT_A, w, ok);
        chk("refused", 16'h0000, {15'h0, ok});
        chk("command kept", {8'h00, `BMSR_CMD_CURRENT}, {8'h00, cmd});
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        finish_test();
    end
    initial begin
        {reset_n, uv, pa, pb, pc, la, lb, lc, cur} = '0;
        {cfg, ana, k1, k2, k3} = {6'h00, 16'h0b9d, 16'h0bb8, 16'h0b9a};
        {m1, m2, m3} = {16'h0aaa, 16'h0777, 16'h0c35};
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        t_protection();
        t_lasting_current();
        t_sense();
        t_freeze_refuse();
        t_reset();
        finish_test();
    end
endmodule // test_battery_monitor_status_readout
